// ---- design/sbr_ram_port.sv ----
// design: two-port synchronous block memory with apb configuration
`timescale 1ns/10ps
module sbr_ram_port
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sbr_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_init_signal,
    input wire sbr_pkg::sbr_port_in_type [sbr_pkg::NUM_PORTS-1:0] port_in,
    output sbr_pkg::sbr_word_type [sbr_pkg::NUM_PORTS-1:0] port_out,
    output logic config_busy
);

    // ========================================================
    // helpers
    function automatic logic reg_hit(
        input logic [sbr_pkg::APB_AW-1:0] a,
        input logic [11:0] off
    );
        reg_hit = (a == off);
    endfunction

    function automatic logic mapped(input logic [sbr_pkg::APB_AW-1:0] a);
        mapped = reg_hit(a, sbr_pkg::OFF_CTRL) |
                 reg_hit(a, sbr_pkg::OFF_STATUS) |
                 reg_hit(a, sbr_pkg::OFF_PRE_ADDR) |
                 reg_hit(a, sbr_pkg::OFF_PRE_DATA) |
                 reg_hit(a, sbr_pkg::OFF_INIT_VAL) |
                 reg_hit(a, sbr_pkg::OFF_OUTPUT_RESET_VALUE);
    endfunction

    // ========================================================
    // storage
    // array is never reset; the clear sweep gives the zero fill instead
    logic [sbr_pkg::WORD_W-1:0] mem [sbr_pkg::DEPTH];

    sbr_pkg::sbr_state_type state, next_state;
    logic [sbr_pkg::ADDR_W-1:0] fill_addr, next_fill_addr;
    logic [sbr_pkg::ADDR_W-1:0] pre_addr, next_pre_addr;
    logic [1:0] mode_cfg [sbr_pkg::NUM_PORTS];
    logic [1:0] next_mode_cfg [sbr_pkg::NUM_PORTS];
    logic [2:0] inv_cfg [sbr_pkg::NUM_PORTS];
    logic [2:0] next_inv_cfg [sbr_pkg::NUM_PORTS];
    logic [sbr_pkg::WORD_W-1:0] init_val [sbr_pkg::NUM_PORTS];
    logic [sbr_pkg::WORD_W-1:0] next_init_val [sbr_pkg::NUM_PORTS];
    logic [sbr_pkg::WORD_W-1:0] output_reset_value [sbr_pkg::NUM_PORTS];
    logic [sbr_pkg::WORD_W-1:0] next_output_reset_value [sbr_pkg::NUM_PORTS];
    logic [31:0] next_prdata;
    logic init_pulse, next_init_pulse;
    logic apb_wr, apb_setup, pre_wr;
    logic [sbr_pkg::NUM_PORTS-1:0] port_wr;
    logic [sbr_pkg::NUM_PORTS-1:0] port_en;

    assign apb_wr = psel & penable & pwrite;
    assign apb_setup = psel & ~penable;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);
    assign config_busy = (state != sbr_pkg::SBR_RUN);
    // preload words only land while loading, never once running
    assign pre_wr = apb_wr & reg_hit(paddr, sbr_pkg::OFF_PRE_DATA) &
                    (state == sbr_pkg::SBR_CFG_LOAD);

    // ========================================================
    // configuration sequence and registers
    always_comb
    begin
        next_state = state;
        next_fill_addr = fill_addr;
        next_pre_addr = pre_addr;
        next_init_pulse = 1'b0;
        next_mode_cfg = mode_cfg;
        next_inv_cfg = inv_cfg;
        next_init_val = init_val;
        next_output_reset_value = output_reset_value;
        case (state)
            sbr_pkg::SBR_CFG_CLEAR:
            begin
                // unspecified locations end up zero
                next_fill_addr = fill_addr + 11'h001;
                if (fill_addr == sbr_pkg::ADDR_LAST)
                begin
                    next_state = sbr_pkg::SBR_CFG_LOAD;
                end
            end
            sbr_pkg::SBR_CFG_LOAD:
            begin
                if (apb_wr && reg_hit(paddr, sbr_pkg::OFF_CTRL) &&
                    pwdata[sbr_pkg::CTRL_DONE_BIT])
                begin
                    next_state = sbr_pkg::SBR_RUN;
                    next_init_pulse = 1'b1;
                end
            end
            sbr_pkg::SBR_RUN:
            begin
                next_state = sbr_pkg::SBR_RUN;
            end
            default:
            begin
                next_state = sbr_pkg::SBR_CFG_CLEAR;
            end
        endcase
        if (apb_wr && reg_hit(paddr, sbr_pkg::OFF_PRE_ADDR))
        begin
            next_pre_addr = pwdata[sbr_pkg::ADDR_W-1:0];
        end
        else if (pre_wr)
        begin
            next_pre_addr = pre_addr + 11'h001;
        end
        for (int p = 0; p < sbr_pkg::NUM_PORTS; p++)
        begin
            if (apb_wr && reg_hit(paddr, sbr_pkg::OFF_CTRL))
            begin
                next_mode_cfg[p] = pwdata[sbr_pkg::CTRL_MODE_POS +
                    p*sbr_pkg::CTRL_MODE_W +: sbr_pkg::CTRL_MODE_W];
                next_inv_cfg[p] = pwdata[sbr_pkg::CTRL_INV_POS +
                    p*sbr_pkg::CTRL_INV_W +: sbr_pkg::CTRL_INV_W];
            end
            if (apb_wr && reg_hit(paddr, sbr_pkg::OFF_INIT_VAL))
            begin
                next_init_val[p] = pwdata[p*sbr_pkg::WORD_STRIDE +:
                    sbr_pkg::WORD_W];
            end
            if (apb_wr && reg_hit(paddr, sbr_pkg::OFF_OUTPUT_RESET_VALUE))
            begin
                next_output_reset_value[p] = pwdata[p*sbr_pkg::WORD_STRIDE +:
                    sbr_pkg::WORD_W];
            end
        end
    end

    // read data is captured in the setup cycle so the access cycle has it
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (apb_setup && !pwrite)
        begin
            if (reg_hit(paddr, sbr_pkg::OFF_CTRL))
            begin
                for (int p = 0; p < sbr_pkg::NUM_PORTS; p++)
                begin
                    next_prdata[sbr_pkg::CTRL_MODE_POS +
                        p*sbr_pkg::CTRL_MODE_W +: sbr_pkg::CTRL_MODE_W]
                        = mode_cfg[p];
                    next_prdata[sbr_pkg::CTRL_INV_POS +
                        p*sbr_pkg::CTRL_INV_W +: sbr_pkg::CTRL_INV_W]
                        = inv_cfg[p];
                end
                next_prdata[sbr_pkg::CTRL_DONE_BIT] = ~config_busy;
            end
            else if (reg_hit(paddr, sbr_pkg::OFF_STATUS))
            begin
                next_prdata[sbr_pkg::STAT_BUSY_BIT] = config_busy;
                next_prdata[sbr_pkg::STAT_CLEAR_BIT] =
                    (state == sbr_pkg::SBR_CFG_CLEAR);
            end
            else if (reg_hit(paddr, sbr_pkg::OFF_PRE_ADDR))
            begin
                next_prdata[sbr_pkg::ADDR_W-1:0] = pre_addr;
            end
            else if (reg_hit(paddr, sbr_pkg::OFF_PRE_DATA))
            begin
                next_prdata[sbr_pkg::WORD_W-1:0] = mem[pre_addr];
            end
            else
            begin
                for (int p = 0; p < sbr_pkg::NUM_PORTS; p++)
                begin
                    if (reg_hit(paddr, sbr_pkg::OFF_INIT_VAL))
                    begin
                        next_prdata[p*sbr_pkg::WORD_STRIDE +:
                            sbr_pkg::WORD_W] = init_val[p];
                    end
                    if (reg_hit(paddr, sbr_pkg::OFF_OUTPUT_RESET_VALUE))
                    begin
                        next_prdata[p*sbr_pkg::WORD_STRIDE +:
                            sbr_pkg::WORD_W] = output_reset_value[p];
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state <= sbr_pkg::SBR_CFG_CLEAR;
            fill_addr <= sbr_pkg::ADDR_RST;
            pre_addr <= sbr_pkg::ADDR_RST;
            init_pulse <= 1'b0;
            prdata <= 32'h0000_0000;
            for (int p = 0; p < sbr_pkg::NUM_PORTS; p++)
            begin
                mode_cfg[p] <= sbr_pkg::MODE_RST;
                inv_cfg[p] <= sbr_pkg::INV_RST;
                init_val[p] <= sbr_pkg::WORD_RST;
                output_reset_value[p] <= sbr_pkg::WORD_RST;
            end
        end
        else
        begin
            state <= next_state;
            fill_addr <= next_fill_addr;
            pre_addr <= next_pre_addr;
            init_pulse <= next_init_pulse;
            prdata <= next_prdata;
            mode_cfg <= next_mode_cfg;
            inv_cfg <= next_inv_cfg;
            init_val <= next_init_val;
            output_reset_value <= next_output_reset_value;
        end
    end

    // ========================================================
    // memory array
    // global init never touches the array, only the output latches
    // on a same-address collision the higher port index lands last
    always_ff @(posedge core_clk)
    begin
        if (state == sbr_pkg::SBR_CFG_CLEAR)
        begin
            mem[fill_addr] <= sbr_pkg::WORD_RST;
        end
        else if (pre_wr)
        begin
            mem[pre_addr] <= pwdata[sbr_pkg::WORD_W-1:0];
        end
        for (int p = 0; p < sbr_pkg::NUM_PORTS; p++)
        begin
            if (port_wr[p])
            begin
                mem[port_in[p].addr] <= {port_in[p].write_parity_in,
                    port_in[p].write_data_in};
            end
        end
    end

    // ========================================================
    // ports
    generate
        for (genvar g = 0; g < sbr_pkg::NUM_PORTS; g++)
        begin : gen_port
            logic we_eff, rst_eff;
            sbr_pkg::sbr_mode_type mode;
            logic [sbr_pkg::WORD_W-1:0] latch, next_latch, din;

            assign port_en[g] = port_in[g].en ^
                inv_cfg[g][sbr_pkg::INV_EN_BIT];
            assign we_eff = port_in[g].we ^
                inv_cfg[g][sbr_pkg::INV_WE_BIT];
            assign rst_eff = port_in[g].sync_output_reset ^
                inv_cfg[g][sbr_pkg::INV_RST_BIT];
            assign mode = sbr_pkg::sbr_mode_type'(mode_cfg[g]);
            assign din = {port_in[g].write_parity_in,
                port_in[g].write_data_in};
            // writes are dropped until configuration is done
            assign port_wr[g] = port_en[g] & we_eff & ~config_busy;

            always_comb
            begin
                next_latch = latch;
                if (global_init_signal || init_pulse)
                begin
                    next_latch = init_val[g];
                end
                else if (!port_en[g])
                begin
                    next_latch = latch;
                end
                else if (rst_eff)
                begin
                    next_latch = output_reset_value[g];
                end
                else if (port_wr[g])
                begin
                    case (mode)
                        sbr_pkg::SBR_WRITE_FIRST: next_latch = din;
                        sbr_pkg::SBR_READ_FIRST:
                            next_latch = mem[port_in[g].addr];
                        sbr_pkg::SBR_NO_CHANGE: next_latch = latch;
                        default: next_latch = din;
                    endcase
                end
                else
                begin
                    next_latch = mem[port_in[g].addr];
                end
            end

            always_ff @(posedge core_clk)
            begin
                if (sys_rst)
                begin
                    latch <= sbr_pkg::WORD_RST;
                end
                else
                begin
                    latch <= next_latch;
                end
            end

            // init value shows at once, no clock edge needed
            assign port_out[g] = global_init_signal ? init_val[g] :
                latch;
        end
    endgenerate

endmodule

// ---- include/sbr_pkg.sv ----
// package: constants and types for the synchronous block memory ports
package sbr_pkg;

    // ========================================================
    // geometry
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int PAR_W = 1;
    localparam int WORD_W = 9;
    localparam int DEPTH = 2048;
    localparam int NUM_PORTS = 2;
    localparam int APB_AW = 12;

    // ========================================================
    // register offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_PRE_ADDR = 12'h008;
    localparam logic [11:0] OFF_PRE_DATA = 12'h00C;
    localparam logic [11:0] OFF_INIT_VAL = 12'h010;
    localparam logic [11:0] OFF_OUTPUT_RESET_VALUE = 12'h014;

    // ========================================================
    // field positions
    localparam int CTRL_MODE_POS = 0;
    localparam int CTRL_MODE_W = 2;
    localparam int CTRL_INV_POS = 4;
    localparam int CTRL_INV_W = 3;
    localparam int CTRL_DONE_BIT = 16;
    localparam int INV_EN_BIT = 0;
    localparam int INV_WE_BIT = 1;
    localparam int INV_RST_BIT = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CLEAR_BIT = 1;
    localparam int WORD_STRIDE = 16;

    // ========================================================
    // reset values
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [2:0] INV_RST = 3'h0;
    localparam logic [8:0] WORD_RST = 9'h000;
    localparam logic [10:0] ADDR_RST = 11'h000;
    localparam logic [10:0] ADDR_LAST = 11'h7FF;

    // ========================================================
    // types
    typedef enum logic [1:0] {
        SBR_WRITE_FIRST,
        SBR_READ_FIRST,
        SBR_NO_CHANGE
    } sbr_mode_type;

    typedef enum logic [1:0] {
        SBR_CFG_CLEAR,
        SBR_CFG_LOAD,
        SBR_RUN
    } sbr_state_type;

    typedef struct packed {
        logic en;
        logic we;
        logic sync_output_reset;
        logic [ADDR_W-1:0] addr;
        logic [PAR_W-1:0] write_parity_in;
        logic [DATA_W-1:0] write_data_in;
    } sbr_port_in_type;

    typedef struct packed {
        logic [PAR_W-1:0] parity;
        logic [DATA_W-1:0] data;
    } sbr_word_type;

endpackage

// ---- dv/sbr_ram_port_assertions.sv ----
// checker: port-level assertions for the block memory ports
`timescale 1ns/10ps
module sbr_checker
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sbr_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic global_init_signal,
    input wire sbr_pkg::sbr_port_in_type [sbr_pkg::NUM_PORTS-1:0] port_in,
    input wire sbr_pkg::sbr_word_type [sbr_pkg::NUM_PORTS-1:0] port_out,
    input wire logic config_busy
);
    // ========================================================
    // shadow registers, built from the bus traffic itself
    logic [31:0] ctrl_sh;
    logic [31:0] srv_sh;
    logic [31:0] init_sh;
    logic [1:0] run_cnt;
    logic wr_go;
    logic done_wr;
    assign wr_go = psel && penable && pwrite;
    assign done_wr = wr_go && paddr == sbr_pkg::OFF_CTRL && pwdata[16];
    // port 0 controls as the port sees them, after the invert bits
    logic en0;
    logic we0;
    logic rst0;
    assign en0 = port_in[0].en ^ ctrl_sh[4];
    assign we0 = port_in[0].we ^ ctrl_sh[5];
    assign rst0 = port_in[0].sync_output_reset ^ ctrl_sh[6];
    // run_cnt masks the one-off init pulse that follows the done write
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctrl_sh <= 32'h0;
            srv_sh <= 32'h0;
            init_sh <= 32'h0;
        end
        else if (wr_go && paddr == sbr_pkg::OFF_CTRL)
            ctrl_sh <= pwdata;
        else if (wr_go && paddr == sbr_pkg::OFF_OUTPUT_RESET_VALUE)
            srv_sh <= pwdata;
        else if (wr_go && paddr == sbr_pkg::OFF_INIT_VAL)
            init_sh <= pwdata;
    end
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || config_busy)
            run_cnt <= 2'h0;
        else if (run_cnt != 2'h3)
            run_cnt <= run_cnt + 2'h1;
    end
    // ========================================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_idle0;
        !en0 && !global_init_signal && run_cnt == 2'h3
            ##1 !global_init_signal;
    endsequence
    sequence s_idle1;
        !port_in[1].en && !ctrl_sh[7] && !global_init_signal
            && run_cnt == 2'h3 ##1 !global_init_signal;
    endsequence
    sequence s_rst0;
        en0 && rst0
            && !global_init_signal && run_cnt == 2'h3 ##1 !global_init_signal;
    endsequence
    chk_idle_hold: assert property (s_idle0 |-> $stable(port_out[0]))
        else $error("port 0 output moved while disabled");
    chk_port_indep: assert property (s_idle1 |-> $stable(port_out[1]))
        else $error("port 1 output moved while disabled");
    chk_sync_reset: assert property (s_rst0
        |-> port_out[0] == srv_sh[8:0])
        else $error("sync reset did not load set value");
    // the written word is the one that stood at the write edge
    chk_write_first: assert property (en0 && we0 && !rst0
        && !config_busy && (ctrl_sh[1:0] == 2'h0 || ctrl_sh[1:0] == 2'h3)
        && !global_init_signal && run_cnt == 2'h3 ##1 !global_init_signal
        |-> port_out[0] == $past({port_in[0].write_parity_in,
        port_in[0].write_data_in}))
        else $error("write first output is not the written word");
    chk_no_change: assert property (en0 && we0 && !rst0
        && ctrl_sh[1:0] == 2'h2 && !config_busy && run_cnt == 2'h3
        && !global_init_signal ##1 !global_init_signal
        |-> $stable(port_out[0]))
        else $error("no change output moved on write");
    chk_init_load: assert property (global_init_signal
        |-> port_out[0] == init_sh[8:0] && port_out[1] == init_sh[24:16])
        else $error("global init value not shown");
    chk_busy_exit: assert property ($fell(config_busy)
        |-> $past(done_wr) || $past(done_wr, 2))
        else $error("configuration ended without done write");
    chk_out_steady: assert property ($changed(port_out[0])
        && run_cnt == 2'h3 |-> $past(en0) || $past(global_init_signal)
        || global_init_signal)
        else $error("port 0 output changed without operation");
endmodule
bind sbr_ram_port sbr_checker sbr_checker_inst (.core_clk, .sys_rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .global_init_signal, .port_in,
    .port_out, .config_busy);

// ---- dv/sbr_user_model.sv ----
// partner: user logic driving both memory ports
`timescale 1ns/10ps
module sbr_user_model
(
    input wire logic core_clk,
    output sbr_pkg::sbr_port_in_type [sbr_pkg::NUM_PORTS-1:0] port_in
);
    // idle level of each raw enable, so an inverted port stays disabled
    logic [1:0] idle_en;
    initial
    begin
        idle_en = 2'h0;
        port_in = '0;
    end
    // one operation, then idle; idle data is flipped so nothing rides on it
    task automatic op(input int p, input logic e, input logic w,
        input logic r, input logic [10:0] a, input logic [8:0] d);
        @(posedge core_clk);
        port_in[p] <= {e, w, r, a, d};
        @(posedge core_clk);
        port_in[p].en <= idle_en[p];
        port_in[p].write_data_in <= ~d[7:0];
    endtask
endmodule

// ---- dv/sbr_ram_port_tb_top.sv ----
// testbench: apb configuration and port scenarios for the block memory
`timescale 1ns/10ps
module sbr_ram_port_tb_top;
    logic core_clk;
    logic sys_rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic global_init_signal;
    logic config_busy;
    sbr_pkg::sbr_port_in_type [sbr_pkg::NUM_PORTS-1:0] port_in;
    sbr_pkg::sbr_word_type [sbr_pkg::NUM_PORTS-1:0] port_out;
    int err_count;
    int tests_run;
    sbr_ram_port sbr_ram_port_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .global_init_signal(global_init_signal),
        .port_in(port_in), .port_out(port_out), .config_busy(config_busy));
    sbr_user_model sbr_user_model_inst (.core_clk(core_clk),
        .port_in(port_in));
    // ========================================================
    // shared tasks
    task automatic test_done;
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp9(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t register %h expected %h", $time, got, exp);
        end
    endtask
    // setup cycle, then access held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            err_count++;
            test_done();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic pop(input int p, input logic e, input logic w,
        input logic r, input logic [10:0] a, input logic [8:0] d,
        input logic [8:0] exp);
        sbr_user_model_inst.op(p, e, w, r, a, d);
        #1;
        cmp9(port_out[p], exp);
    endtask
    // ========================================================
    // scenarios
    task automatic s_config;
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, sbr_pkg::OFF_STATUS, 32'h0, q, e);
            n++;
        end
        while (q[sbr_pkg::STAT_CLEAR_BIT] !== 1'b0 && n < 1000);
        if (n >= 1000)
        begin
            err_count++;
            test_done();
        end
        cmp32(q, 32'h00000001);
        pop(0, 1'b1, 1'b1, 1'b0, 11'h003, 9'h1EE, 9'h000);
        cmp32({31'h0, config_busy}, 32'h00000001);
        wr(sbr_pkg::OFF_PRE_ADDR, 32'h000007FE);
        wr(sbr_pkg::OFF_PRE_DATA, 32'h000001A5);
        wr(sbr_pkg::OFF_PRE_DATA, 32'h0000005A);
        wr(sbr_pkg::OFF_INIT_VAL, 32'h00C3013C);
        wr(sbr_pkg::OFF_OUTPUT_RESET_VALUE, 32'h01F0000F);
        wr(sbr_pkg::OFF_CTRL, 32'h00010000);
        repeat (4) @(posedge core_clk);
        #1;
        cmp9(port_out[0], 9'h13C);
        cmp9(port_out[1], 9'h0C3);
        cmp32({31'h0, config_busy}, 32'h00000000);
        apb(1'b0, sbr_pkg::OFF_STATUS, 32'h0, q, e);
        cmp32(q, 32'h00000000);
        apb(1'b0, 12'h020, 32'h0, q, e);
        cmp32({31'h0, e}, 32'h00000001);
        pop(0, 1'b1, 1'b0, 1'b0, 11'h7FE, 9'h000, 9'h1A5);
        pop(0, 1'b1, 1'b0, 1'b0, 11'h7FF, 9'h000, 9'h05A);
        pop(0, 1'b1, 1'b0, 1'b0, 11'h003, 9'h000, 9'h000);
    endtask
    // every mode code, the unused one behaving as write first
    task automatic s_modes;
        logic [8:0] w1;
        logic [8:0] w2;
        logic [10:0] a;
        for (int m = 0; m < 4; m++)
        begin
            w1 = 9'h101 + 9'(m);
            w2 = 9'h0F0 + 9'(m);
            a = 11'h100 + 11'(m);
            wr(sbr_pkg::OFF_CTRL, 32'h00010000 | 32'(m));
            pop(0, 1'b1, 1'b0, 1'b0, a, 9'h000, 9'h000);
            pop(0, 1'b1, 1'b1, 1'b0, a, w1,
                (m == 0 || m == 3) ? w1 : 9'h000);
            pop(0, 1'b1, 1'b1, 1'b0, a, w2, (m == 0 || m == 3) ? w2
                : (m == 1) ? w1 : 9'h000);
            pop(0, 1'b1, 1'b0, 1'b0, a, 9'h000, w2);
        end
        wr(sbr_pkg::OFF_CTRL, 32'h00010000);
    endtask
    task automatic s_reset;
        pop(0, 1'b1, 1'b1, 1'b1, 11'h200, 9'h0AA, 9'h00F);
        pop(0, 1'b1, 1'b0, 1'b0, 11'h200, 9'h000, 9'h0AA);
        pop(1, 1'b1, 1'b0, 1'b1, 11'h000, 9'h000, 9'h1F0);
    endtask
    task automatic s_init;
        @(posedge core_clk);
        global_init_signal <= 1'b1;
        #1;
        cmp9(port_out[0], 9'h13C);
        @(posedge core_clk);
        global_init_signal <= 1'b0;
        #1;
        cmp9(port_out[1], 9'h0C3);
        pop(0, 1'b1, 1'b0, 1'b0, 11'h200, 9'h000, 9'h0AA);
    endtask
    // port 1 enable inverted; port 0 must not notice
    // then port 0 write enable and output reset inverted as well
    task automatic s_invert;
        wr(sbr_pkg::OFF_CTRL, 32'h00010080);
        sbr_user_model_inst.idle_en[1] = 1'b1;
        pop(1, 1'b0, 1'b1, 1'b0, 11'h300, 9'h155, 9'h155);
        pop(1, 1'b1, 1'b1, 1'b0, 11'h300, 9'h000, 9'h155);
        cmp9(port_out[0], 9'h0AA);
        pop(0, 1'b1, 1'b0, 1'b0, 11'h300, 9'h000, 9'h155);
        wr(sbr_pkg::OFF_CTRL, 32'h000100E0);
        pop(0, 1'b1, 1'b0, 1'b1, 11'h301, 9'h0C5, 9'h0C5);
        pop(0, 1'b1, 1'b1, 1'b0, 11'h301, 9'h000, 9'h00F);
        pop(0, 1'b1, 1'b1, 1'b1, 11'h301, 9'h000, 9'h0C5);
    endtask
    // ========================================================
    // clock, reset and main sequence
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial
    begin
        err_count = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        global_init_signal = 1'b0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        s_config();
        s_modes();
        s_reset();
        s_init();
        s_invert();
        test_done();
    end
endmodule
